// ---- hdl/flash_cmd_fault_control.sv ----
`timescale 1ns/10ps
`include "flash_cmd_fault_control_params.svh"
// Contract
// - command done interrupt follows its enable
// - ignore bit suppresses single fault reporting
// - force double makes every read flag double
// - force single makes every read flag single unless ignore is set
// - without force, flags follow real faults
// - force bits clear only by software
// - double fault interrupt gated by enable
// - single fault interrupt gated by enable
// - status bit access classes, others zero
// - status reset may show init double fault
// - section verify checks blank, sets done
// - section verify needs slot index two
// - bad address, alignment, boundary, mode: error
// - verify results track errors and blank fails
// - read once returns four words, phrase 0-7
// - security register loaded at reset, read-only
// - option register shows eight nonvolatile bits
// - factory test registers read zero
// - writes ignored while command executes
module flash_cmd_fault_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic secureMode,
  input wire logic specialMode,
  output logic arrayReq,
  output logic [17:0] arrayAddr,
  output logic arrayInfo,
  input wire logic arrayAck,
  input wire logic [63:0] arrayData,
  input wire logic arraySingleFault,
  input wire logic arrayDoubleFault,
  output logic cmdDoneIrq,
  output logic doubleFaultIrq,
  output logic singleFaultIrq
);

  flash_cmd_fault_control_pkg::seq_state_type state_q;
  logic [5:0] clockDivider_q;
  logic [7:0] security_q;
  logic [7:0] userOption_q;
  logic [2:0] slotIndex_q;
  logic cmdDoneIe_q;
  logic ignoreSf_q;
  logic forceDf_q;
  logic forceSf_q;
  logic dfIe_q;
  logic sfIe_q;
  logic cmdDone_q;
  logic access_error_flag_q;
  logic protViol_q;
  logic [1:0] verify_q;
  logic dfFlag_q;
  logic sfFlag_q;
  logic [15:0] params_q [0:5];
  logic [15:0] remaining_q;
  logic [17:0] nextAddr_q;

  // write channel capture; address and data may arrive in any order
  logic awHeld_q;
  logic wHeld_q;
  logic [4:0] wIdx_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic wLane0;
  logic canWrite;
  logic launch;
  logic [7:0] wByte;

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wLane0 = doWrite && wStrb_q[0];
  assign wByte = wData_q[7:0];
  assign canWrite = wLane0 && (state_q != flash_cmd_fault_control_pkg::SEQ_VERIFY)
    && (state_q != flash_cmd_fault_control_pkg::SEQ_ONCE);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wIdx_q <= 5'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        wIdx_q <= s_axi_awaddr[6:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wIdx_q) ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [4:0] idx);
    case (idx)
      `IDX_CLOCK_DIVIDER, `IDX_SECURITY, `IDX_SLOT_INDEX, `IDX_CONFIG,
      `IDX_ERR_ENABLE, `IDX_STATUS, `IDX_ERR_STATUS, `IDX_PARAM_HI,
      `IDX_PARAM_LO, `IDX_FACTORY_A, `IDX_FACTORY_B, `IDX_OPTION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // read channel
  logic [7:0] rByte;

  always_comb
  begin
    rByte = 8'h00;
    case (s_axi_araddr[6:2])
      `IDX_CLOCK_DIVIDER: rByte = {2'b00, clockDivider_q};
      `IDX_SECURITY: rByte = security_q;
      `IDX_SLOT_INDEX: rByte = {5'h00, slotIndex_q};
      `IDX_CONFIG: rByte = {cmdDoneIe_q, 2'b00, ignoreSf_q, 2'b00, forceDf_q, forceSf_q};
      `IDX_ERR_ENABLE: rByte = {6'h00, dfIe_q, sfIe_q};
      `IDX_STATUS: rByte = {cmdDone_q, 1'b0, access_error_flag_q, protViol_q,
        state_q == flash_cmd_fault_control_pkg::SEQ_VERIFY
        || state_q == flash_cmd_fault_control_pkg::SEQ_ONCE,
        1'b0, verify_q};
      `IDX_ERR_STATUS: rByte = {6'h00, dfFlag_q, sfFlag_q};
      `IDX_PARAM_HI: rByte = (slotIndex_q <= 3'h5) ? params_q[slotIndex_q][15:8] : 8'h00;
      `IDX_PARAM_LO: rByte = (slotIndex_q <= 3'h5) ? params_q[slotIndex_q][7:0] : 8'h00;
      `IDX_FACTORY_A, `IDX_FACTORY_B: rByte = 8'h00;
      `IDX_OPTION: rByte = userOption_q;
      default: rByte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rByte};
        s_axi_rresp <= mapped(s_axi_araddr[6:2]) ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // launch checks
  logic cmdAllowed;
  logic verifyBad;
  logic onceBad;
  logic [11:0] firstPhrase;
  logic [12:0] endPhrase;

  assign launch = canWrite && wIdx_q == `IDX_STATUS && wByte[`ST_CMD_DONE]
    && cmdDone_q && state_q == flash_cmd_fault_control_pkg::SEQ_IDLE;
  // only the secured special mode locks these two commands out
  assign cmdAllowed = !(secureMode && specialMode);
  assign firstPhrase = {params_q[1][13:3], 1'b0} >> 1;
  assign endPhrase = {1'b0, firstPhrase} + params_q[2][12:0];
  assign verifyBad = slotIndex_q != `SLOT_VERIFY_LAUNCH
    || !cmdAllowed
    || {params_q[0][1:0], params_q[1][15:14]} != `PFLASH_TOP_BITS
    || params_q[1][2:0] != 3'h0
    || params_q[2][15:12] != 4'h0
    || endPhrase > {1'b0, `PFLASH_PHRASES};
  assign onceBad = slotIndex_q != `SLOT_ONCE_LAUNCH || !cmdAllowed
    || params_q[1] > `ONCE_LAST_PHRASE;

  // fault detection on every array read
  logic dfSet;
  logic sfSet;

  assign dfSet = arrayAck && (forceDf_q || arrayDoubleFault);
  assign sfSet = arrayAck && !ignoreSf_q && (forceSf_q || arraySingleFault);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dfFlag_q <= 1'b0;
      sfFlag_q <= 1'b0;
    end
    else
    begin
      // a new fault wins over a clear in the same cycle
      dfFlag_q <= dfSet || (dfFlag_q
        && !(canWrite && wIdx_q == `IDX_ERR_STATUS && wByte[`ERR_DF]));
      sfFlag_q <= sfSet || (sfFlag_q
        && !(canWrite && wIdx_q == `IDX_ERR_STATUS && wByte[`ERR_SF]));
    end
  end

  // software configuration
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clockDivider_q <= 6'h00;
      slotIndex_q <= 3'h0;
      cmdDoneIe_q <= 1'b0;
      ignoreSf_q <= 1'b0;
      forceDf_q <= 1'b0;
      forceSf_q <= 1'b0;
      dfIe_q <= 1'b0;
      sfIe_q <= 1'b0;
    end
    else if (canWrite)
    begin
      case (wIdx_q)
        `IDX_CLOCK_DIVIDER: clockDivider_q <= wByte[5:0];
        `IDX_SLOT_INDEX: slotIndex_q <= wByte[2:0];
        `IDX_CONFIG:
        begin
          cmdDoneIe_q <= wByte[`CFG_CMD_DONE_IE];
          ignoreSf_q <= wByte[`CFG_IGNORE_SF];
          forceDf_q <= wByte[`CFG_FORCE_DF];
          forceSf_q <= wByte[`CFG_FORCE_SF];
        end
        `IDX_ERR_ENABLE:
        begin
          dfIe_q <= wByte[`ERR_DF];
          sfIe_q <= wByte[`ERR_SF];
        end
        default: ;
      endcase
    end
  end

  // parameter words; read once results land in slots 2 to 5
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : gSlot
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          params_q[g] <= 16'h0000;
        end
        else if (state_q == flash_cmd_fault_control_pkg::SEQ_ONCE && arrayAck && g >= 2)
        begin
          // modulo keeps the select in range for slots 2 to 5; slots 0 and 1 never load
          params_q[g] <= arrayData[63 - 16 * ((g + 2) % 4) -: 16];
        end
        else if (canWrite && slotIndex_q == 3'(g) && wIdx_q == `IDX_PARAM_HI)
        begin
          params_q[g][15:8] <= wByte;
        end
        else if (canWrite && slotIndex_q == 3'(g) && wIdx_q == `IDX_PARAM_LO)
        begin
          params_q[g][7:0] <= wByte;
        end
      end
    end
  endgenerate

  // command sequencer and status
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= flash_cmd_fault_control_pkg::SEQ_INIT;
      cmdDone_q <= 1'b0;
      access_error_flag_q <= 1'b0;
      protViol_q <= 1'b0;
      verify_q <= 2'b00;
      security_q <= `RESET_BYTE;
      userOption_q <= `RESET_BYTE;
      remaining_q <= 16'h0000;
      nextAddr_q <= 18'h00000;
      arrayReq <= 1'b0;
      arrayAddr <= 18'h00000;
      arrayInfo <= 1'b0;
    end
    else
    begin
      if (canWrite && wIdx_q == `IDX_STATUS)
      begin
        if (wByte[`ST_ACC_ERR])
          access_error_flag_q <= 1'b0;
        if (wByte[`ST_PROT_VIOL])
          protViol_q <= 1'b0;
      end
      case (state_q)
        flash_cmd_fault_control_pkg::SEQ_INIT:
        begin
          arrayReq <= !arrayAck;
          arrayAddr <= `CONFIG_PHRASE_ADDR;
          arrayInfo <= 1'b0;
          if (arrayAck)
          begin
            security_q <= arrayData[7:0];
            userOption_q <= arrayData[15:8];
            verify_q <= {1'b0, arrayDoubleFault};
            cmdDone_q <= 1'b1;
            state_q <= flash_cmd_fault_control_pkg::SEQ_IDLE;
          end
        end
        flash_cmd_fault_control_pkg::SEQ_IDLE:
        begin
          if (launch)
          begin
            verify_q <= 2'b00;
            if (params_q[0][15:8] == `CMD_SECTION_VERIFY && verifyBad)
              access_error_flag_q <= 1'b1;
            else if (params_q[0][15:8] == `CMD_SECTION_VERIFY)
            begin
              cmdDone_q <= 1'b0;
              remaining_q <= params_q[2];
              nextAddr_q <= {params_q[0][1:0], params_q[1]};
              state_q <= flash_cmd_fault_control_pkg::SEQ_VERIFY;
            end
            else if (params_q[0][15:8] == `CMD_READ_ONCE && !onceBad)
            begin
              cmdDone_q <= 1'b0;
              arrayReq <= 1'b1;
              arrayInfo <= 1'b1;
              arrayAddr <= {params_q[1][14:0], 3'h0};
              state_q <= flash_cmd_fault_control_pkg::SEQ_ONCE;
            end
            else
              access_error_flag_q <= 1'b1;
          end
        end
        flash_cmd_fault_control_pkg::SEQ_VERIFY:
        begin
          arrayInfo <= 1'b0;
          if (arrayAck)
          begin
            arrayReq <= 1'b0;
            remaining_q <= remaining_q - 16'h0001;
            nextAddr_q <= nextAddr_q + 18'h00008;
            if (arrayDoubleFault || arrayData != 64'hffff_ffff_ffff_ffff)
              verify_q <= 2'b11;
            else if (arraySingleFault)
              verify_q[1] <= 1'b1;
          end
          else if (remaining_q == 16'h0000)
          begin
            cmdDone_q <= 1'b1;
            state_q <= flash_cmd_fault_control_pkg::SEQ_IDLE;
          end
          else
          begin
            arrayReq <= 1'b1;
            arrayAddr <= nextAddr_q;
          end
        end
        flash_cmd_fault_control_pkg::SEQ_ONCE:
        begin
          if (arrayAck)
          begin
            arrayReq <= 1'b0;
            arrayInfo <= 1'b0;
            if (arrayDoubleFault)
              verify_q <= 2'b11;
            else if (arraySingleFault)
              verify_q[1] <= 1'b1;
            cmdDone_q <= 1'b1;
            state_q <= flash_cmd_fault_control_pkg::SEQ_IDLE;
          end
        end
        default: state_q <= flash_cmd_fault_control_pkg::SEQ_IDLE;
      endcase
    end
  end

  // interrupt levels
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmdDoneIrq <= 1'b0;
      doubleFaultIrq <= 1'b0;
      singleFaultIrq <= 1'b0;
    end
    else
    begin
      cmdDoneIrq <= cmdDoneIe_q && cmdDone_q;
      doubleFaultIrq <= dfIe_q && dfFlag_q;
      singleFaultIrq <= sfIe_q && sfFlag_q;
    end
  end

endmodule : flash_cmd_fault_control

// ---- inc/flash_cmd_fault_control_params.svh ----
`ifndef FLASH_CMD_FAULT_CONTROL_PARAMS_SVH
`define FLASH_CMD_FAULT_CONTROL_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_CLOCK_DIVIDER 5'h00
`define IDX_SECURITY 5'h01
`define IDX_SLOT_INDEX 5'h02
`define IDX_CONFIG 5'h04
`define IDX_ERR_ENABLE 5'h05
`define IDX_STATUS 5'h06
`define IDX_ERR_STATUS 5'h07
`define IDX_PARAM_HI 5'h0a
`define IDX_PARAM_LO 5'h0b
`define IDX_FACTORY_A 5'h0c
`define IDX_FACTORY_B 5'h0d
`define IDX_OPTION 5'h10

// controller_config_reg fields
`define CFG_CMD_DONE_IE 7
`define CFG_IGNORE_SF 4
`define CFG_FORCE_DF 1
`define CFG_FORCE_SF 0
// error enable / error status fields
`define ERR_DF 1
`define ERR_SF 0
// command_status_reg fields
`define ST_CMD_DONE 7
`define ST_ACC_ERR 5
`define ST_PROT_VIOL 4
`define ST_BUSY 3
`define ST_VERIFY1 1
`define ST_VERIFY0 0

// command codes and slot indices
`define CMD_SECTION_VERIFY 8'h03
`define CMD_READ_ONCE 8'h04
`define SLOT_VERIFY_LAUNCH 3'h2
`define SLOT_ONCE_LAUNCH 3'h1
`define ONCE_LAST_PHRASE 16'h0007

// program flash window: global address 0x3_c000 to 0x3_ffff
`define PFLASH_TOP_BITS 4'hf
`define PFLASH_PHRASES 12'h800
// phrase holding the option byte and security byte
`define CONFIG_PHRASE_ADDR 18'h3ff08

`define RESET_BYTE 8'h00
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ---- inc/flash_cmd_fault_control_pkg.sv ----
package flash_cmd_fault_control_pkg;

  typedef enum logic [1:0] {
    SEQ_INIT,
    SEQ_IDLE,
    SEQ_VERIFY,
    SEQ_ONCE
  } seq_state_type;

endpackage : flash_cmd_fault_control_pkg

// ---- sim/flash_cmd_fault_control_checker.sv ----
`timescale 1ns/10ps
module flash_cmd_fault_control_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic arrayReq,
  input wire logic [17:0] arrayAddr,
  input wire logic arrayInfo,
  input wire logic arrayAck,
  input wire logic doubleFaultIrq,
  input wire logic singleFaultIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  req_hold_a: assert property (arrayReq && !arrayAck |=> arrayReq)
    else $error("array request dropped before ack");
  req_drop_a: assert property (arrayReq && arrayAck |=> !arrayReq)
    else $error("array request kept after ack");
  addr_stable_a: assert property (arrayReq && !arrayAck |=> $stable({arrayAddr, arrayInfo}))
    else $error("array address moved during request");
  init_read_a: assert property ($past(rst) |-> ##[0:2] (arrayReq && arrayAddr == 18'h3ff08))
    else $error("no config phrase read after reset");
  once_range_a: assert property (arrayReq && arrayInfo |-> arrayAddr <= 18'h38)
    else $error("read once phrase out of range");
  pflash_window_a: assert property (arrayReq && !arrayInfo |-> arrayAddr[17:14] == 4'hf
    && arrayAddr[2:0] == 3'h0)
    else $error("array read outside aligned window");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");

  cover property (arrayReq && arrayInfo);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (doubleFaultIrq && singleFaultIrq);
endmodule : flash_cmd_fault_control_checker

bind flash_cmd_fault_control flash_cmd_fault_control_checker checker_i (.core_clk, .rst,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .arrayReq, .arrayAddr, .arrayInfo, .arrayAck, .doubleFaultIrq,
  .singleFaultIrq);

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`include "flash_cmd_fault_control_params.svh"
module testbench;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, secureMode, specialMode, arrayReq, arrayInfo, arrayAck;
  logic arraySingleFault, arrayDoubleFault, cmdDoneIrq, doubleFaultIrq, singleFaultIrq;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [17:0] arrayAddr, expAddr;
  logic [63:0] arrayData, lastData, d;
  logic [31:0] seed = 32'hc76e6e4d;
  logic [31:0] r;
  logic [7:0] rv, cfg;
  logic blank, injSf, injDf, expInfo, sf, df;
  int errCount = 0;
  int numChecks = 0;
  int ackCnt = 0;

  flash_cmd_fault_control uut (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    numChecks++;
    if (s !== e)
    begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic closeOut();
    if (errCount == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : closeOut

  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] i);
    @(posedge core_clk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [4:0] i, input logic [7:0] e);
    rd(i);
    chk($sformatf("reg %0h", i), 18'(rv), 18'(e));
  endtask : rc

  task automatic poll();
    do rd(`IDX_STATUS); while (rv[7] !== 1'b1);
  endtask : poll

  // bw goes to config right after launch; a busy block must drop it
  task automatic cmd(input logic [47:0] p, input logic [2:0] ix, input logic [7:0] bw);
    for (int k = 0; k < 3; k++)
    begin
      wr(`IDX_SLOT_INDEX, 8'(k));
      wr(`IDX_PARAM_HI, p[47 - 16 * k -: 8]);
      wr(`IDX_PARAM_LO, p[39 - 16 * k -: 8]);
    end
    wr(`IDX_SLOT_INDEX, {5'h0, ix});
    wr(`IDX_STATUS, 8'h80);
    wr(`IDX_CONFIG, bw);
    chk("doneIrq", 18'(cmdDoneIrq), 18'(bw[7]));
    poll();
  endtask : cmd

  task automatic errCase(input logic [47:0] p, input logic [2:0] ix);
    wr(`IDX_CONFIG, 8'h80);
    ackCnt = 0;
    cmd(p, ix, 8'h80);
    chk("status", 18'(rv), 18'ha0);
    chk("acks", 18'(ackCnt), 18'h0);
    wr(`IDX_STATUS, 8'h20);
  endtask : errCase

  // slow random acks keep commands busy long enough to probe them
  always @(posedge core_clk)
  begin
    r = xs();
    if (arrayAck)
      arrayAck <= 1'b0;
    else if (arrayReq && r[2:0] == 3'h0)
    begin
      d = blank ? '1 : {xs(), xs()};
      chk("arrayAddr", arrayAddr, expAddr);
      chk("arrayInfo", 18'(arrayInfo), 18'(expInfo));
      expAddr = expAddr + 18'h8;
      lastData = d;
      ackCnt++;
      arrayData <= d;
      arraySingleFault <= injSf;
      arrayDoubleFault <= injDf;
      arrayAck <= 1'b1;
    end
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    errCount++;
    closeOut();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {secureMode, specialMode, arrayAck, arraySingleFault, arrayDoubleFault} = '0;
    {injSf, injDf, blank, expInfo} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, arrayData} = '0;
    s_axi_wstrb = 4'h1;
    expAddr = `CONFIG_PHRASE_ADDR;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    poll();
    chk("status", 18'(rv), 18'h80);
    rc(`IDX_SECURITY, lastData[7:0]);
    rc(`IDX_OPTION, lastData[15:8]);
    wr(`IDX_SECURITY, ~lastData[7:0]);
    rc(`IDX_SECURITY, lastData[7:0]);
    wr(`IDX_FACTORY_A, 8'hff);
    rc(`IDX_FACTORY_A, 8'h00);
    wr(`IDX_FACTORY_B, 8'hff);
    rc(`IDX_FACTORY_B, 8'h00);
    wr(5'h1f, 8'h01);
    chk("bresp", 18'(resp), 18'(`AXI_SLVERR));
    rd(5'h1f);
    chk("rresp", 18'(resp), 18'(`AXI_SLVERR));
    wr(`IDX_CONFIG, 8'hff);
    rc(`IDX_CONFIG, 8'h93);
    wr(`IDX_CLOCK_DIVIDER, 8'h18);
    rc(`IDX_CLOCK_DIVIDER, 8'h18);
    wr(`IDX_ERR_ENABLE, 8'h03);
    wr(`IDX_STATUS, 8'h7f);
    rc(`IDX_STATUS, 8'h80);
    for (int p = 0; p < 8; p++)
    begin
      cfg = p == 5 ? 8'h11 : (p > 5 ? 8'h03 : 8'h00);
      wr(`IDX_CONFIG, cfg);
      wr(`IDX_ERR_STATUS, 8'h03);
      injSf <= lastData[0];
      injDf <= lastData[1];
      expAddr = 18'(p * 8);
      expInfo = 1'b1;
      cmd({8'h04, 8'h00, 16'(p), 16'h0}, 3'h1, cfg);
      df = injDf | cfg[1];
      sf = (injSf | cfg[0]) & ~cfg[4];
      rc(`IDX_ERR_STATUS, {6'h0, df, sf});
      chk("faultIrq", 18'({doubleFaultIrq, singleFaultIrq}), 18'({df, sf}));
      for (int w = 0; w < 4; w++)
      begin
        wr(`IDX_SLOT_INDEX, 8'(w + 2));
        rc(`IDX_PARAM_HI, lastData[63 - 16 * w -: 8]);
        rc(`IDX_PARAM_LO, lastData[55 - 16 * w -: 8]);
      end
    end
    rc(`IDX_CONFIG, 8'h03);
    wr(`IDX_ERR_ENABLE, 8'h00);
    rc(`IDX_ERR_ENABLE, 8'h00);
    chk("faultIrq", 18'({doubleFaultIrq, singleFaultIrq}), 18'h0);
    wr(`IDX_CONFIG, 8'h80);
    injSf <= 1'b0;
    injDf <= 1'b0;
    blank <= 1'b1;
    expInfo = 1'b0;
    expAddr = 18'h3fff0;
    ackCnt = 0;
    cmd({16'h0303, 16'hfff0, 16'h2}, 3'h2, 8'h00);
    chk("acks", 18'(ackCnt), 18'h2);
    chk("status", 18'(rv), 18'h80);
    chk("doneIrq", 18'(cmdDoneIrq), 18'h1);
    rc(`IDX_CONFIG, 8'h80);
    blank <= 1'b0;
    expAddr = 18'h3fff0;
    cmd({16'h0303, 16'hfff0, 16'h1}, 3'h2, 8'h00);
    chk("status", 18'(rv), 18'h83);
    blank <= 1'b1;
    injSf <= 1'b1;
    expAddr = 18'h3fff0;
    cmd({16'h0303, 16'hfff0, 16'h1}, 3'h2, 8'h00);
    chk("status", 18'(rv), 18'h82);
    injSf <= 1'b0;
    errCase({16'h0303, 16'hfff0, 16'h2}, 3'h1);
    errCase({16'h0303, 16'hfff1, 16'h1}, 3'h2);
    errCase({16'h0303, 16'hfff8, 16'h2}, 3'h2);
    errCase({16'h0302, 16'hfff0, 16'h1}, 3'h2);
    errCase({16'h0400, 16'h0008, 16'h0}, 3'h1);
    secureMode <= 1'b1;
    specialMode <= 1'b1;
    errCase({16'h0303, 16'hfff0, 16'h1}, 3'h2);
    secureMode <= 1'b0;
    specialMode <= 1'b0;
    rc(`IDX_STATUS, 8'h80);
    expAddr = `CONFIG_PHRASE_ADDR;
    injDf <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    poll();
    chk("status", 18'(rv), 18'h81);
    closeOut();
  end
endmodule : testbench
